// File: otp_spi_pkg.sv
package otp_spi_pkg;

	// Command bytes
	localparam logic [7:0] CMD_NONE = 8'h00;
	localparam logic [7:0] CMD_STATUS_WR = 8'h01;
	localparam logic [7:0] CMD_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_WRITE_DIS = 8'h04;
	localparam logic [7:0] CMD_STATUS_RD = 8'h05;
	localparam logic [7:0] CMD_WRITE_EN = 8'h06;
	localparam logic [7:0] CMD_LOCK = 8'h85;

	// Status byte layout
	localparam int STAT_WRITE_EN = 5;
	localparam int STAT_READY_NOT = 4;
	localparam int STAT_INFO_SEL = 3;
	localparam int STAT_LOCK = 2;

	// Lock byte in the info page
	localparam logic [15:0] LOCK_INFO_ADDR = 16'h0023;
	localparam logic [7:0] UNLOCKED_BYTE = 8'hFF;
	localparam logic [7:0] LOCK_BYTE = 8'h00;
	localparam logic [7:0] REFUSED_BYTE = 8'h00;

	// Timing and sizes
	localparam int PROGRAM_CYCLES = 1600;
	localparam logic [8:0] MAX_PROGRAM_BYTES = 9'h100;
	localparam int FIFO_DEPTH = 2;

	// Position of the byte within one command
	localparam logic [1:0] BYTE_CMD = 2'h0;
	localparam logic [1:0] BYTE_ADDR_HI = 2'h1;
	localparam logic [1:0] BYTE_ADDR_LO = 2'h2;
	localparam logic [1:0] BYTE_DATA = 2'h3;

	// Reset levels of the synchronised pins: sck, csn_n, mosi
	localparam logic [2:0] PINS_IDLE = 3'h2;

	typedef enum logic [2:0] {
		ST_BOOT_RD,
		ST_BOOT_WAIT,
		ST_BOOT_CAP,
		ST_IDLE,
		ST_PROGRAM,
		ST_LOCK
	} ctl_state_t;

	typedef struct packed {
		logic sck;
		logic csn_n;
		logic mosi;
	} spi_pins_t;

	typedef struct packed {
		logic en;
		logic info;
		logic [15:0] addr;
	} otp_rd_t;

	typedef struct packed {
		logic en;
		logic info;
		logic [15:0] addr;
		logic [7:0] data;
	} otp_ld_t;

endpackage

// File: otp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module otp_pin_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Asynchronous levels in, core-domain levels out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	if (W < 1) begin : g_chk
		$error("otp_pin_sync: W must be at least 1");
	end

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_ff <= RST_VAL;
			q_ff <= RST_VAL;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;

endmodule
`default_nettype wire

// File: otp_byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module otp_byte_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("otp_byte_fifo: DEPTH must be a power of two, at least 2");
	end

	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	assign in_ready = cnt_ff != FULL;
	assign out_valid = cnt_ff != '0;
	assign out_data = mem_ff[rd_ff];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	// Flush drops everything, including a word pushed in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst || flush) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff <= wr_ff + AW'(push);
			rd_ff <= rd_ff + AW'(pop);
			cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

endmodule
`default_nettype wire

// File: otp_spi_port.sv
// How it works
// - Lock command is one byte shifted in while chip select is low.
// - Lock programming starts at chip select rise and lasts 1600 core cycles.
// - While a sequence runs, every command except status read is ignored.
// - Write enable clears when the lock sequence completes.
// - Nothing but a start-up read can ever clear the lock flag.
// - At start-up info byte 0x23 is read; 0xFF unlocks, anything else locks.
// - Internal controller can request the same lock-byte write.
// - A set lock flag refuses programming of main block and info page.
// - A set lock flag returns zero instead of main block contents.
// - SPI pins are asynchronous and pass two flops before use.
// - SPI clock up to 8 MHz; lower rates equally accepted.
// - Ready-not status bit stays 1 while programming runs.
// - Command 0x85 sets lock flag and writes 0x00 to info byte 0x23.
// - Command 0x06 sets the write enable bit.
// - Command 0x05 repeats the status byte while chip select stays low.
`timescale 1ns/1ps
`default_nettype none
module otp_spi_port
	import otp_spi_pkg::*;
#(
	parameter int PROGRAM_CYCLES_P = PROGRAM_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// SPI pins
	input wire logic spi_sck,
	input wire logic spi_csn_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	// Internal controller
	input wire logic mcu_lock_req,
	// Array read port, data one cycle after the request
	output otp_rd_t otp_rd,
	input wire logic [7:0] otp_rdata,
	// Array page-latch load and program strobe
	output otp_ld_t otp_ld,
	output logic program_busy,
	// Status
	output logic readback_locked
);

	localparam logic [15:0] CYC_LAST = 16'(PROGRAM_CYCLES_P - 1);

	if (PROGRAM_CYCLES_P < 1 || PROGRAM_CYCLES_P > 65535) begin : g_chk
		$error("otp_spi_port: PROGRAM_CYCLES_P out of range");
	end

	spi_pins_t pins_s;
	ctl_state_t state_ff;
	ctl_state_t nxt_state;
	logic sck_d_ff;
	logic csn_d_ff;
	logic [2:0] bit_cnt_ff;
	logic [6:0] sh_in_ff;
	logic [1:0] byte_idx_ff;
	logic [7:0] cmd_ff;
	logic [15:0] addr_ff;
	logic [8:0] nbytes_ff;
	logic program_voltage_pin_ok_ff;
	logic wen_ff;
	logic info_page_select_ff;
	logic lock_ff;
	logic [7:0] tx_ff;
	logic load_pend_ff;
	logic oe_ff;
	logic fetch_on_ff;
	logic rd_wait_ff;
	otp_rd_t rd_ff;
	otp_ld_t ld_ff;
	logic [15:0] cyc_ff;
	logic [8:0] left_ff;
	logic busy_ff;
	logic [7:0] status_byte;
	logic [7:0] tx_next;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;

	// SPI pins are unrelated to clk; replies need about four clk per SCK half period, so 8 MHz wants a faster clk
	otp_pin_sync #(.W($bits(spi_pins_t)), .RST_VAL(PINS_IDLE)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d({spi_sck, spi_csn_n, spi_mosi}),
		.q(pins_s)
	);

	// Edge and byte decode
	wire active = ~pins_s.csn_n;
	wire sck_rise = active & pins_s.sck & ~sck_d_ff;
	wire sck_fall = active & ~pins_s.sck & sck_d_ff;
	wire csn_end = pins_s.csn_n & ~csn_d_ff;
	wire byte_done = sck_rise & (bit_cnt_ff == 3'h7);
	wire [7:0] rx_byte = {sh_in_ff, pins_s.mosi};
	wire ctl_busy = state_ff != ST_IDLE;
	wire cmd_take = byte_done & (byte_idx_ff == BYTE_CMD);
	wire cmd_ok = ~ctl_busy | (rx_byte == CMD_STATUS_RD);
	wire [7:0] cmd_now = cmd_ok ? rx_byte : CMD_NONE;
	wire addr_hi_done = byte_done & (byte_idx_ff == BYTE_ADDR_HI);
	wire addr_lo_done = byte_done & (byte_idx_ff == BYTE_ADDR_LO);
	wire data_done = byte_done & (byte_idx_ff == BYTE_DATA);
	wire status_wr = addr_hi_done & (cmd_ff == CMD_STATUS_WR);
	wire program_voltage_pin_byte = data_done & (cmd_ff == CMD_PROGRAM) & program_voltage_pin_ok_ff & ~lock_ff & (nbytes_ff != MAX_PROGRAM_BYTES);
	wire program_voltage_pin_start = csn_end & (cmd_ff == CMD_PROGRAM) & program_voltage_pin_ok_ff & (nbytes_ff != 9'h000);
	wire lock_start_spi = csn_end & (cmd_ff == CMD_LOCK) & wen_ff;
	// A request that meets a program byte load is dropped, else the lock byte load would be lost
	wire lock_start = lock_start_spi | (mcu_lock_req & ~ctl_busy & ~csn_end & ~program_voltage_pin_byte);
	wire in_seq = (state_ff == ST_PROGRAM) | (state_ff == ST_LOCK);
	wire seq_done = in_seq & (cyc_ff == CYC_LAST) & (left_ff == 9'h001);
	wire fetch_go = fetch_on_ff & fifo_in_ready & ~rd_ff.en & ~rd_wait_ff;
	wire push = rd_wait_ff & fetch_on_ff;
	wire [7:0] push_data = (lock_ff & ~info_page_select_ff) ? REFUSED_BYTE : otp_rdata;
	wire tx_load = sck_fall & load_pend_ff;
	wire pop = tx_load & (cmd_ff == CMD_READ);

	always_comb begin
		status_byte = 8'h00;
		status_byte[STAT_WRITE_EN] = wen_ff;
		status_byte[STAT_READY_NOT] = ctl_busy;
		status_byte[STAT_INFO_SEL] = info_page_select_ff;
		status_byte[STAT_LOCK] = lock_ff;
	end

	always_comb begin
		tx_next = 8'h00;
		if (cmd_ff == CMD_STATUS_RD) begin
			tx_next = status_byte;
		end else if (cmd_ff == CMD_READ && fifo_out_valid) begin
			tx_next = fifo_out_data;
		end
	end

	// Read data buffer; a slow SCK simply leaves the fetch stalled
	otp_byte_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.flush(~active),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(push_data),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sck_d_ff <= 1'b0;
			csn_d_ff <= 1'b1;
			oe_ff <= 1'b0;
		end else begin
			sck_d_ff <= pins_s.sck;
			csn_d_ff <= pins_s.csn_n;
			oe_ff <= active;
		end
	end

	// Serial receive, MSB first, sampled on SCK rise
	always_ff @(posedge clk) begin
		if (sys_rst || !active) begin
			bit_cnt_ff <= 3'h0;
			sh_in_ff <= 7'h00;
			byte_idx_ff <= BYTE_CMD;
		end else if (sck_rise) begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			sh_in_ff <= rx_byte[6:0];
			if (byte_done && byte_idx_ff != BYTE_DATA) begin
				byte_idx_ff <= byte_idx_ff + 2'h1;
			end
		end
	end

	// Command, address and byte count
	always_ff @(posedge clk) begin
		if (sys_rst || csn_end) begin
			cmd_ff <= CMD_NONE;
			program_voltage_pin_ok_ff <= 1'b0;
			nbytes_ff <= 9'h000;
		end else begin
			if (cmd_take) begin
				cmd_ff <= cmd_now;
				program_voltage_pin_ok_ff <= wen_ff & ~lock_ff;
			end
			if (program_voltage_pin_byte) begin
				nbytes_ff <= nbytes_ff + 9'h001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_ff <= 16'h0000;
		end else if (addr_hi_done) begin
			addr_ff[15:8] <= rx_byte;
		end else if (addr_lo_done) begin
			addr_ff[7:0] <= rx_byte;
		end else if (program_voltage_pin_byte || fetch_go) begin
			addr_ff <= addr_ff + 16'h0001;
		end
	end

	// Status bits
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wen_ff <= 1'b0;
			info_page_select_ff <= 1'b0;
		end else if (seq_done) begin
			wen_ff <= 1'b0;
		end else if (csn_end && cmd_ff == CMD_PROGRAM) begin
			wen_ff <= program_voltage_pin_start & wen_ff;
		end else if (cmd_take && cmd_now == CMD_WRITE_EN) begin
			wen_ff <= 1'b1;
		end else if (cmd_take && cmd_now == CMD_WRITE_DIS) begin
			wen_ff <= 1'b0;
		end else if (status_wr) begin
			wen_ff <= rx_byte[STAT_WRITE_EN];
			info_page_select_ff <= rx_byte[STAT_INFO_SEL];
		end
	end

	// Locked until the start-up read proves the byte blank; only that read clears it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lock_ff <= 1'b1;
		end else if (state_ff == ST_BOOT_CAP) begin
			lock_ff <= otp_rdata != UNLOCKED_BYTE;
		end else if (seq_done && state_ff == ST_LOCK) begin
			lock_ff <= 1'b1;
		end
	end

	// Serial transmit, changed on SCK fall
	always_ff @(posedge clk) begin
		if (sys_rst || !active) begin
			tx_ff <= 8'h00;
			load_pend_ff <= 1'b0;
		end else begin
			if (byte_done) begin
				load_pend_ff <= (cmd_take && cmd_now == CMD_STATUS_RD) || (!cmd_take && cmd_ff == CMD_STATUS_RD)
					|| (cmd_ff == CMD_READ && (addr_lo_done || data_done));
			end else if (sck_fall) begin
				load_pend_ff <= 1'b0;
			end
			if (tx_load) begin
				tx_ff <= tx_next;
			end else if (sck_fall) begin
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
		end
	end

	// Array read: start-up probe, then prefetch for READ
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_ff <= '0;
			rd_wait_ff <= 1'b0;
			fetch_on_ff <= 1'b0;
		end else begin
			rd_wait_ff <= rd_ff.en;
			fetch_on_ff <= active & (fetch_on_ff | (addr_lo_done & (cmd_ff == CMD_READ)));
			if (state_ff == ST_BOOT_RD) begin
				rd_ff <= '{en: 1'b1, info: 1'b1, addr: LOCK_INFO_ADDR};
			end else if (fetch_go) begin
				rd_ff <= '{en: 1'b1, info: info_page_select_ff, addr: addr_ff};
			end else begin
				rd_ff.en <= 1'b0;
			end
		end
	end

	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_BOOT_RD: nxt_state = ST_BOOT_WAIT;
			ST_BOOT_WAIT: nxt_state = ST_BOOT_CAP;
			ST_BOOT_CAP: nxt_state = ST_IDLE;
			ST_IDLE: begin
				if (program_voltage_pin_start) begin
					nxt_state = ST_PROGRAM;
				end else if (lock_start) begin
					nxt_state = ST_LOCK;
				end
			end
			ST_PROGRAM, ST_LOCK: begin
				if (seq_done) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_BOOT_RD;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff <= ST_BOOT_RD;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			busy_ff <= (nxt_state == ST_PROGRAM) || (nxt_state == ST_LOCK);
		end
	end

	// Each byte takes PROGRAM_CYCLES_P cycles
	always_ff @(posedge clk) begin
		if (sys_rst || !in_seq) begin
			cyc_ff <= 16'h0000;
			left_ff <= (program_voltage_pin_start && state_ff == ST_IDLE) ? nbytes_ff : 9'h001;
		end else if (cyc_ff == CYC_LAST) begin
			cyc_ff <= 16'h0000;
			left_ff <= left_ff - 9'h001;
		end else begin
			cyc_ff <= cyc_ff + 16'h0001;
		end
	end

	// Page latch load; locked device never loads program data, only the lock byte at info 0x23
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ld_ff <= '0;
		end else if (program_voltage_pin_byte) begin
			ld_ff <= '{en: 1'b1, info: info_page_select_ff, addr: addr_ff, data: rx_byte};
		end else if (lock_start && !program_voltage_pin_start && state_ff == ST_IDLE) begin
			ld_ff <= '{en: 1'b1, info: 1'b1, addr: LOCK_INFO_ADDR, data: LOCK_BYTE};
		end else begin
			ld_ff.en <= 1'b0;
		end
	end

	assign spi_miso = tx_ff[7];
	assign spi_miso_oe = oe_ff;
	assign otp_rd = rd_ff;
	assign otp_ld = ld_ff;
	assign program_busy = busy_ff;
	assign readback_locked = lock_ff;

	// Checks
	logic [19:0] busy_len_ff;
	logic [8:0] run_len_ff;
	always_ff @(posedge clk) begin
		if (sys_rst || !busy_ff) begin
			busy_len_ff <= 20'h00000;
		end else begin
			busy_len_ff <= busy_len_ff + 20'h00001;
		end
		if (busy_ff && !in_seq) begin
			run_len_ff <= 9'h000;
		end else if (in_seq && cyc_ff == 16'h0000 && busy_len_ff == 20'h00000) begin
			run_len_ff <= left_ff;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_seq_end;
		$fell(busy_ff) ##0 (state_ff == ST_IDLE);
	endsequence

	property p_seq_length;
		s_seq_end |-> 32'(busy_len_ff) == 32'(run_len_ff) * PROGRAM_CYCLES_P;
	endproperty
	a_seq_length: assert property (p_seq_length) else $error("sequence length wrong");

	property p_ignore_busy;
		(cmd_take && ctl_busy && rx_byte != CMD_STATUS_RD) |=> cmd_ff == CMD_NONE;
	endproperty
	a_ignore_busy: assert property (p_ignore_busy) else $error("command taken while busy");

	property p_wen_clear;
		s_seq_end |-> !wen_ff;
	endproperty
	a_wen_clear: assert property (p_wen_clear) else $error("write enable left set");

	property p_lock_sticky;
		(lock_ff && state_ff != ST_BOOT_CAP) |=> lock_ff;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock flag cleared");

	property p_boot_decide;
		(state_ff == ST_BOOT_CAP) |=> (lock_ff == ($past(otp_rdata) != UNLOCKED_BYTE)) && state_ff == ST_IDLE;
	endproperty
	a_boot_decide: assert property (p_boot_decide) else $error("start-up lock decision wrong");

	// Loads outside a sequence come from program frames, which a set lock must stop
	property p_load_refused;
		(otp_ld.en && !busy_ff) |-> !$past(lock_ff);
	endproperty
	a_load_refused: assert property (p_load_refused) else $error("load while locked");

	property p_lock_load;
		(state_ff == ST_IDLE && nxt_state == ST_LOCK) |=> otp_ld.en && otp_ld.info && otp_ld.addr == LOCK_INFO_ADDR
			&& otp_ld.data == LOCK_BYTE && busy_ff;
	endproperty
	a_lock_load: assert property (p_lock_load) else $error("lock byte not loaded");

	property p_refuse_read;
		(push && lock_ff && !info_page_select_ff) |=> (fifo_out_valid && fifo_out_data == REFUSED_BYTE) || !active;
	endproperty
	a_refuse_read: assert property (p_refuse_read) else $error("main data read while locked");

	property p_start_busy;
		(program_voltage_pin_start && state_ff == ST_IDLE) |=> busy_ff ##1 busy_ff;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("sequence did not start");

	property p_ready_not;
		(tx_load && cmd_ff == CMD_STATUS_RD) |=> tx_ff[STAT_READY_NOT] == $past(ctl_busy);
	endproperty
	a_ready_not: assert property (p_ready_not) else $error("ready-not bit wrong");

endmodule
`default_nettype wire

// File: spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
	// Core clock, used only to pace the link
	input wire logic clk,
	// SPI pins
	output logic spi_sck,
	output logic spi_csn_n,
	output logic spi_mosi,
	input wire logic spi_miso
);
	// Mode 0, 320 ns period; the clock stays low between frames
	initial begin
		spi_sck = 1'b0;
		spi_csn_n = 1'b1;
		spi_mosi = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Chip select falls before any bit is shifted
	task automatic start();
		wait_clk(4);
		spi_csn_n = 1'b0;
		wait_clk(4);
	endtask

	// Released data line carries garbage so a stale bit is never trusted
	task automatic stop();
		wait_clk(4);
		spi_csn_n = 1'b1;
		spi_mosi = ~spi_mosi;
		wait_clk(6);
	endtask

	// MSB first, 4 core cycles per half period keeps the rate below the limit
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			spi_mosi = tx[i];
			wait_clk(4);
			spi_sck = 1'b1;
			rx[i] = spi_miso;
			wait_clk(4);
			spi_sck = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// File: otp_spi_readback_lock_program_voltage_pin_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
	$display("MISMATCH at %0t: got %h expected %h", $time, (a), (b)); end end
module otp_spi_readback_lock_program_voltage_pin_bench
	import otp_spi_pkg::*;
;
	// Short sequence length keeps the run brief
	localparam int PC = 200;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] dat;
		logic [7:0] st;
	} row_t;
	logic clk, sys_rst, mcu_lock_req, spi_sck, spi_csn_n, spi_mosi, spi_miso, spi_miso_oe;
	logic program_busy, readback_locked;
	otp_rd_t otp_rd;
	otp_ld_t otp_ld;
	logic [7:0] otp_rdata;
	logic [7:0] main_mem [0:255];
	logic [7:0] info_mem [0:255];
	logic [7:0] s, q0, q1;
	int err_total, total_checks, busy_cnt;
	row_t rows [0:4] = '{'{CMD_WRITE_EN, 8'h00, 8'h20}, '{CMD_WRITE_DIS, 8'h00, 8'h00},
		'{CMD_STATUS_WR, 8'hFF, 8'h28}, '{CMD_STATUS_WR, 8'h08, 8'h08}, '{CMD_STATUS_WR, 8'h00, 8'h00}};
	logic [7:0] boot_vals [0:2] = '{8'h00, 8'h7F, 8'hFF};

	otp_spi_port #(.PROGRAM_CYCLES_P(PC)) u_otp_spi_port (.clk(clk), .sys_rst(sys_rst),
		.spi_sck(spi_sck), .spi_csn_n(spi_csn_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe), .mcu_lock_req(mcu_lock_req), .otp_rd(otp_rd),
		.otp_rdata(otp_rdata), .otp_ld(otp_ld), .program_busy(program_busy),
		.readback_locked(readback_locked));
	spi_master_model u_spi_master_model (.clk(clk), .spi_sck(spi_sck), .spi_csn_n(spi_csn_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Array model: bits only ever clear; read data is garbage outside its valid cycle
	always @(posedge clk) begin
		if (otp_ld.en === 1'b1 && otp_ld.info) info_mem[otp_ld.addr[7:0]] <= info_mem[otp_ld.addr[7:0]] & otp_ld.data;
		if (otp_ld.en === 1'b1 && !otp_ld.info) main_mem[otp_ld.addr[7:0]] <= main_mem[otp_ld.addr[7:0]] & otp_ld.data;
		if (otp_rd.en === 1'b1) otp_rdata <= otp_rd.info ? info_mem[otp_rd.addr[7:0]] : main_mem[otp_rd.addr[7:0]];
		else otp_rdata <= ~otp_rdata;
		if (program_busy === 1'b1) busy_cnt <= busy_cnt + 1;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic frame(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		u_spi_master_model.start();
		u_spi_master_model.xfer(c, r);
		if (c == CMD_STATUS_WR) u_spi_master_model.xfer(d, r);
		u_spi_master_model.stop();
	endtask

	task automatic stat(output logic [7:0] s1);
		logic [7:0] r, s2;
		u_spi_master_model.start();
		`CHK(spi_miso_oe, 1'b1);
		u_spi_master_model.xfer(CMD_STATUS_RD, r);
		u_spi_master_model.xfer(8'h00, s1);
		u_spi_master_model.xfer(8'h00, s2);
		u_spi_master_model.stop();
		`CHK(spi_miso_oe, 1'b0);
		`CHK(s2, s1);
	endtask

	// Two data bytes keep the run short; production bursts run 64 to 256
	task automatic acc(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d0, d1,
		output logic [7:0] r0, r1);
		logic [7:0] r;
		u_spi_master_model.start();
		u_spi_master_model.xfer(c, r);
		u_spi_master_model.xfer(a[15:8], r);
		u_spi_master_model.xfer(a[7:0], r);
		u_spi_master_model.xfer(d0, r0);
		u_spi_master_model.xfer(d1, r1);
		u_spi_master_model.stop();
	endtask

	task automatic wait_idle();
		for (int n = 0; n < 4 * PC && program_busy !== 1'b0; n++) tick(1);
		`CHK(program_busy, 1'b0);
	endtask

	// Reset pulse then start-up read of the lock byte
	task automatic do_reset(input logic [7:0] b);
		info_mem[8'h23] = b;
		sys_rst = 1'b1;
		tick(8);
		`CHK(readback_locked, 1'b1);
		sys_rst = 1'b0;
		tick(10);
		`CHK(readback_locked, b != 8'hFF);
	endtask

	task automatic finish_test();
		$display("Checks %0d, errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#2ms;
		err_total++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		finish_test();
	end

	initial begin
		err_total = 0;
		total_checks = 0;
		busy_cnt = 0;
		mcu_lock_req = 1'b0;
		otp_rdata = 8'h00;
		for (int i = 0; i < 256; i++) begin
			main_mem[i] = 8'hFF;
			info_mem[i] = 8'hFF;
		end
		do_reset(8'hFF);
		// Programming voltage settle, scaled down
		tick(50);
		foreach (rows[i]) begin
			frame(rows[i].cmd, rows[i].dat);
			stat(s);
			`CHK(s, rows[i].st);
		end
		// Lock without write enable must do nothing
		frame(CMD_LOCK, 8'h00);
		tick(20);
		`CHK(program_busy, 1'b0);
		`CHK(readback_locked, 1'b0);
		// Program two bytes, then try to drop write enable while busy; it stays set until completion
		frame(CMD_WRITE_EN, 8'h00);
		acc(CMD_PROGRAM, 16'h0010, 8'hA5, 8'h3C, q0, q1);
		`CHK(program_busy, 1'b1);
		frame(CMD_WRITE_DIS, 8'h00);
		stat(s);
		`CHK(s, 8'((1 << STAT_WRITE_EN) | (1 << STAT_READY_NOT)));
		wait_idle();
		stat(s);
		`CHK(s, 8'h00);
		acc(CMD_READ, 16'h0010, 8'h00, 8'h00, q0, q1);
		`CHK(q0, 8'hA5);
		`CHK(q1, 8'h3C);
		// Lock sequence length and its effects
		frame(CMD_WRITE_EN, 8'h00);
		busy_cnt = 0;
		frame(CMD_LOCK, 8'h00);
		wait_idle();
		`CHK(busy_cnt, PC);
		`CHK(readback_locked, 1'b1);
		`CHK(info_mem[8'h23], 8'h00);
		stat(s);
		`CHK(s, 8'(1 << STAT_LOCK));
		acc(CMD_READ, 16'h0010, 8'h00, 8'h00, q0, q1);
		`CHK(q0, 8'h00);
		// Programming refused on both the main block and the info page
		for (int i = 0; i < 2; i++) begin
			frame(CMD_STATUS_WR, i ? 8'h28 : 8'h20);
			acc(CMD_PROGRAM, 16'h0030, 8'h12, 8'h34, q0, q1);
			`CHK(program_busy, 1'b0);
			`CHK(i ? info_mem[8'h30] : main_mem[8'h30], 8'hFF);
		end
		// Restart keeps the lock; fresh lock byte values decide the flag
		do_reset(info_mem[8'h23]);
		foreach (boot_vals[i]) do_reset(boot_vals[i]);
		// Internal controller lock request
		mcu_lock_req = 1'b1;
		tick(1);
		mcu_lock_req = 1'b0;
		for (int n = 0; n < 3 && otp_ld.en !== 1'b1; n++) tick(1);
		`CHK(otp_ld, otp_ld_t'{1'b1, 1'b1, 16'h0023, 8'h00});
		wait_idle();
		`CHK(readback_locked, 1'b1);
		finish_test();
	end
endmodule
`default_nettype wire
